// *** rtl/rsrd_pkg.sv ***
package rsrd_pkg;
    // Four-level strap codes
    localparam logic [1:0] LVL_L0 = 2'h0;
    localparam logic [1:0] LVL_L1 = 2'h1;
    localparam logic [1:0] LVL_L2 = 2'h2;
    localparam logic [1:0] LVL_L3 = 2'h3;
    // Operating mode codes (mode strap level)
    localparam logic [1:0] MODE_PIN    = 2'h0;
    localparam logic [1:0] MODE_CTRL   = 2'h1;
    localparam logic [1:0] MODE_TARGET = 2'h2;
    // Gain codes driven out: 0=+6dB 1=-3dB 2=+3dB 3=0dB
    localparam logic [1:0] GAIN_P6 = 2'h0;
    localparam logic [1:0] GAIN_M3 = 2'h1;
    localparam logic [1:0] GAIN_P3 = 2'h2;
    localparam logic [1:0] GAIN_Z0 = 2'h3;
    // Reset values
    localparam logic [3:0] EQ_RESET   = 4'h0;
    localparam logic [1:0] GAIN_RESET = GAIN_Z0;
    // Detect hit counts per control level
    localparam logic [1:0] HITS_L1 = 2'h3;
    localparam logic [1:0] HITS_L2 = 2'h2;
    localparam logic [1:0] HITS_L3 = 2'h1;
    // Poll period
    localparam int CLK_HZ        = 20000000;
    localparam int POLL_US       = 150;
    localparam int POLL_CYCLES   = (POLL_US * (CLK_HZ / 1000000));
    // Register map, word offsets as byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_EQ0    = 8'h04;
    localparam logic [7:0] REG_EQ1    = 8'h08;
    localparam logic [7:0] REG_GAIN   = 8'h0C;
    localparam logic [7:0] REG_CTRL   = 8'h10;
    // Status field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_DET_BIT  = 4;
    localparam int ST_TERM_BIT = 5;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage : rsrd_pkg

// *** rtl/rsrd_strap_latch.sv ***
`timescale 1ns/1ps
// Captures one resolved four-level strap after reset release and holds it
module rsrd_strap_latch
    import rsrd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] strapLevel,
    output logic      [1:0] heldLevel
);
    logic taken;   // Set once the strap has been sampled

    // Sample at the first edge after release; async reset loads constants only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            heldLevel <= LVL_L0;
            taken     <= 1'b0;
        end else if (!taken) begin
            heldLevel <= strapLevel;
            taken     <= 1'b1;
        end
    end
endmodule : rsrd_strap_latch

// *** rtl/rsrd_rx_detect.sv ***
`timescale 1ns/1ps
// Receiver-detect machine: polls far-end termination, counts hits
module rsrd_rx_detect
    import rsrd_pkg::*;
#(
    parameter int POLL_CNT = POLL_CYCLES
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       powerDown,
    input  wire logic [1:0] detectLevel,
    input  wire logic       manualRestart,
    input  wire logic       farTermSeen,
    output logic            pollStrobe,
    output logic            detected,
    output logic            termOn
);
    typedef enum {S_IDLE, S_WAIT, S_DONE} rsrd_det_type;
    rsrd_det_type state;
    logic [31:0]  timer;        // Poll interval counter
    logic [1:0]   hits;         // Consecutive valid results
    wire  [1:0]   needHits = (detectLevel == LVL_L1) ? HITS_L1 :
                             (detectLevel == LVL_L2) ? HITS_L2 : HITS_L3;
    wire          enabled  = !powerDown && (detectLevel != LVL_L0);
    wire          timerEnd = (timer == 32'(POLL_CNT - 1));
    wire          hitNow   = pollStrobe && farTermSeen;

    // Machine; power-down acts as held manual reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            timer <= 32'h00000000;
            hits  <= 2'h0;
            pollStrobe <= 1'b0;
            detected   <= 1'b0;
            termOn     <= 1'b0;
        end else if (powerDown) begin
            state <= S_IDLE;
            timer <= 32'h00000000;
            hits  <= 2'h0;
            pollStrobe <= 1'b0;
            detected   <= 1'b0;
            termOn     <= 1'b0;
        end else if (!enabled) begin
            state <= S_IDLE;
            hits  <= 2'h0;
            pollStrobe <= 1'b0;
            detected   <= 1'b0;
            termOn     <= 1'b1;
        end else begin
            pollStrobe <= 1'b0;
            case (state)
                S_IDLE: begin
                    state   <= manualRestart ? S_IDLE : S_WAIT;
                    timer   <= 32'h00000000;
                    hits    <= 2'h0;
                    detected <= 1'b0;
                    termOn  <= 1'b0;
                end
                S_WAIT: begin
                    if (manualRestart) begin
                        state <= S_IDLE;
                    end else if (timerEnd) begin
                        timer      <= 32'h00000000;
                        pollStrobe <= 1'b1;
                    end else begin
                        timer <= timer + 32'h00000001;
                    end
                    // A restart in a poll cycle wins over that poll's result
                    if (pollStrobe && !manualRestart) begin
                        if (!farTermSeen) begin
                            hits <= 2'h0;
                        end else if (hits + 2'h1 >= needHits) begin
                            state    <= S_DONE;
                            detected <= 1'b1;
                            termOn   <= 1'b1;
                        end else begin
                            hits <= hits + 2'h1;
                        end
                    end
                end
                S_DONE: begin
                    if (manualRestart) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    chk_pd_hiz_term: assert property (@(posedge clk) disable iff (rst)
        powerDown |=> !termOn) else $error("termination on during power-down");
    chk_disabled_term: assert property (@(posedge clk) disable iff (rst)
        (!powerDown && detectLevel == LVL_L0) |=> termOn && !detected) else $error("disabled detect not 50 ohm");
    chk_single_hit: assert property (@(posedge clk) disable iff (rst)
        (enabled && detectLevel == LVL_L3 && hitNow && state == S_WAIT && !manualRestart
         && $stable(detectLevel)) ##1 enabled |-> detected) else $error("one hit did not detect at L3");
    chk_miss_clears: assert property (@(posedge clk) disable iff (rst)
        (enabled && state == S_WAIT && pollStrobe && !farTermSeen && !manualRestart) |=> hits == 2'h0)
        else $error("miss did not restart count");
    chk_hiz_before: assert property (@(posedge clk) disable iff (rst)
        (enabled && !detected) |-> !termOn) else $error("termination before detect");
endmodule : rsrd_rx_detect

// *** rtl/rsrd_config.sv ***
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Bank index is four times high plus low.
// - Strap pair 0 to bank 0, pair 1.
// - Straps steer equalizer only in pin mode.
// - Serial modes take equalizer from register writes.
// - Detect runs at power-up and manual restart.
// - Detect level zero: machine off, 50 ohm.
// - Enabled: high impedance until detect, then 50.
// - Poll each 150 us; 3/2/1 hits; miss restarts.
// - Power-down forces reset and high impedance.
// - Gain strap maps to 6, -3, 3, 0 dB.
// - Serial modes take gain from register writes.
// - Each strap resolved to one of four levels.
// - Mode strap selects pin, controller, target, reserved.
module rsrd_config
    import rsrd_pkg::*;
#(
    parameter int POLL_CNT = POLL_CYCLES
)(
    input  wire logic        clk,
    input  wire logic        rst,
    // Resolved four-level straps
    input  wire logic [1:0]  modeStrap,
    input  wire logic [1:0]  gainStrap,
    input  wire logic [1:0]  boostHighStrapBank0,
    input  wire logic [1:0]  boostLowStrapBank0,
    input  wire logic [1:0]  boostHighStrapBank1,
    input  wire logic [1:0]  boostLowStrapBank1,
    input  wire logic [1:0]  terminationSenseControl,
    input  wire logic        powerDownInput,
    input  wire logic        farTermSeen,
    // Avalon-MM slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             response,
    // Configuration outputs
    output logic      [3:0]  eqIndexBank0,
    output logic      [3:0]  eqIndexBank1,
    output logic      [1:0]  dcGainCode,
    output logic             pollStrobe,
    output logic             rxDetected,
    output logic             inputTermOn
);
    ////////////////////////////////////////////////////////////////////////////
    // Strap capture
    logic [1:0] heldLevel [0:6];   // mode, gain, eq straps, detect control
    wire  [1:0] strapIn   [0:6];
    assign strapIn[0] = modeStrap;
    assign strapIn[1] = gainStrap;
    assign strapIn[2] = boostHighStrapBank0;
    assign strapIn[3] = boostLowStrapBank0;
    assign strapIn[4] = boostHighStrapBank1;
    assign strapIn[5] = boostLowStrapBank1;
    assign strapIn[6] = terminationSenseControl;

    // One latch per strap
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_strap
            rsrd_strap_latch u_latch (
                .clk        (clk),
                .rst        (rst),
                .strapLevel (strapIn[gi]),
                .heldLevel  (heldLevel[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Mode and pin-derived settings
    wire       pinMode   = (heldLevel[0] == MODE_PIN);
    wire       serMode   = (heldLevel[0] == MODE_CTRL) || (heldLevel[0] == MODE_TARGET);
    wire [3:0] pinEq0    = {heldLevel[2], heldLevel[3]};
    wire [3:0] pinEq1    = {heldLevel[4], heldLevel[5]};
    wire [1:0] pinGain   = (heldLevel[1] == LVL_L0) ? GAIN_P6 :
                           (heldLevel[1] == LVL_L1) ? GAIN_M3 :
                           (heldLevel[1] == LVL_L2) ? GAIN_P3 : GAIN_Z0;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [3:0] regEq0;      // Software equalizer, bank 0
    logic [3:0] regEq1;      // Software equalizer, bank 1
    logic [1:0] regGain;     // Software gain code
    logic       regRestart;  // One-cycle manual detect restart
    logic       pending;     // Access accepted, answer next cycle

    wire access   = (read || write) && !pending;
    wire wrLane0  = write && access && byteenable[0];
    wire hitEq0   = (address == REG_EQ0);
    wire hitEq1   = (address == REG_EQ1);
    wire hitGain  = (address == REG_GAIN);
    wire hitCtrl  = (address == REG_CTRL);
    wire hitStat  = (address == REG_STATUS);
    wire mapped   = hitEq0 || hitEq1 || hitGain || hitCtrl || hitStat;
    wire [31:0] statusWord = {26'h0, inputTermOn, rxDetected, 2'h0, heldLevel[0]};
    wire [31:0] next_readdata = hitStat ? statusWord :
                                hitEq0  ? {28'h0, regEq0} :
                                hitEq1  ? {28'h0, regEq1} :
                                hitGain ? {30'h0, regGain} : UNMAPPED_READ;

    // Fixed one wait state: request sampled, answered next edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending     <= 1'b0;
            waitrequest <= 1'b1;
        end else begin
            pending     <= access;
            waitrequest <= !access;
        end
    end

    // Read data and slave error for unmapped addresses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h00000000;
            response <= 1'b0;
        end else if (access) begin
            readdata <= read ? next_readdata : 32'h00000000;
            response <= !mapped;
        end
    end

    // Writes; only serial modes may change the eq and gain registers, pin mode keeps straps in charge; a restart write works in any mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regEq0     <= EQ_RESET;
            regEq1     <= EQ_RESET;
            regGain    <= GAIN_RESET;
            regRestart <= 1'b0;
        end else begin
            regRestart <= wrLane0 && hitCtrl && writedata[0];
            if (wrLane0 && serMode && hitEq0) begin
                regEq0 <= writedata[3:0];
            end
            if (wrLane0 && serMode && hitEq1) begin
                regEq1 <= writedata[3:0];
            end
            if (wrLane0 && serMode && hitGain) begin
                regGain <= writedata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output selection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eqIndexBank0 <= EQ_RESET;
            eqIndexBank1 <= EQ_RESET;
            dcGainCode   <= GAIN_RESET;
        end else if (pinMode) begin
            eqIndexBank0 <= pinEq0;
            eqIndexBank1 <= pinEq1;
            dcGainCode   <= pinGain;
        end else begin
            eqIndexBank0 <= regEq0;
            eqIndexBank1 <= regEq1;
            dcGainCode   <= regGain;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver detect
    logic strapsReady;   // High from the edge that latches the straps
    // Detect is held in manual reset until the straps are taken. Otherwise the
    // reset code L0 would read as detect off and glitch the inputs to 50 ohm.
    wire  detectHold = powerDownInput || !strapsReady;

    // Marks the end of strap capture; async reset loads a constant only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strapsReady <= 1'b0;
        end else begin
            strapsReady <= 1'b1;
        end
    end

    rsrd_rx_detect #(
        .POLL_CNT (POLL_CNT)
    ) u_detect (
        .clk           (clk),
        .rst           (rst),
        .powerDown     (detectHold),
        .detectLevel   (heldLevel[6]),
        .manualRestart (regRestart),
        .farTermSeen   (farTermSeen),
        .pollStrobe    (pollStrobe),
        .detected      (rxDetected),
        .termOn        (inputTermOn)
    );

    chk_pin_eq: assert property (@(posedge clk) disable iff (rst)
        pinMode && $stable(heldLevel[2]) && $stable(heldLevel[3]) |=>
        eqIndexBank0 == 4'($past(heldLevel[2]) * 4 + $past(heldLevel[3]))) else $error("bank0 index wrong");
    chk_pin_gain: assert property (@(posedge clk) disable iff (rst)
        pinMode && heldLevel[1] == LVL_L3 && $stable(heldLevel[1]) |=> dcGainCode == GAIN_Z0)
        else $error("gain code wrong");
    chk_ser_eq: assert property (@(posedge clk) disable iff (rst)
        !pinMode && $stable(regEq1) |=> eqIndexBank1 == $past(regEq1))
        else $error("straps used outside pin mode");
endmodule : rsrd_config

// *** bench/rsrd_far_term_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far-end receiver termination, answering each detect poll
module rsrd_far_term_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       pollStrobe,
    input  wire logic       present,
    input  wire logic [7:0] dropAt,
    output logic            farTermSeen
);
    logic       [7:0] pollCount;                       // Polls seen since reset
    logic             wander;                          // Idle pattern, flips every cycle
    wire  logic [7:0] next_pollCount = pollCount + 8'h01;
    // Sense result only means something in a poll cycle, so idle shows noise
    assign farTermSeen = pollStrobe ? (present && (next_pollCount != dropAt)) : wander;
    // Poll counter picks which poll is answered as a miss
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pollCount <= 8'h00;
            wander    <= 1'b0;
        end else begin
            wander <= ~wander;
            if (pollStrobe) begin
                pollCount <= next_pollCount;
            end
        end
    end
endmodule : rsrd_far_term_model

// *** bench/redriver_strap_config_rx_detect_tb_top.sv ***
`timescale 1ns/1ps
module redriver_strap_config_rx_detect_tb_top import rsrd_pkg::*; ;
    typedef struct packed {logic [1:0] mode, gain, h0, l0, h1, l1, gainExp;} rsrd_row_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] modeStrap = MODE_PIN, gainStrap = LVL_L3, termCtl = LVL_L0;
    logic [1:0] hi0 = LVL_L0, lo0 = LVL_L0, hi1 = LVL_L0, lo1 = LVL_L0;
    logic powerDownInput = 1'b0, present = 1'b1, farTermSeen;
    logic [7:0] address = 8'h00, dropAt = 8'h00;
    logic read = 1'b0, write = 1'b0, waitrequest, response;
    logic [31:0] writedata = 32'h00000000, readdata;
    logic [3:0] eqIndexBank0, eqIndexBank1;
    logic [1:0] dcGainCode;
    logic pollStrobe, rxDetected, inputTermOn;
    int mismatches = 0;
    int n_checks = 0;
    // Strap rows: pin mode decodes straps, serial modes keep register resets
    rsrd_row_type rows [6] = '{
        '{MODE_PIN, LVL_L0, LVL_L0, LVL_L0, LVL_L3, LVL_L3, GAIN_P6},
        '{MODE_PIN, LVL_L1, LVL_L1, LVL_L2, LVL_L2, LVL_L1, GAIN_M3},
        '{MODE_PIN, LVL_L2, LVL_L3, LVL_L0, LVL_L0, LVL_L3, GAIN_P3},
        '{MODE_PIN, LVL_L3, LVL_L2, LVL_L3, LVL_L1, LVL_L1, GAIN_Z0},
        '{MODE_TARGET, LVL_L0, LVL_L3, LVL_L3, LVL_L3, LVL_L3, GAIN_RESET},
        '{MODE_CTRL, LVL_L1, LVL_L1, LVL_L1, LVL_L1, LVL_L1, GAIN_RESET}};
    always #25 clk = ~clk;
    rsrd_config #(.POLL_CNT(8)) rsrd_config_i (.clk(clk), .rst(rst), .modeStrap(modeStrap),
        .gainStrap(gainStrap), .boostHighStrapBank0(hi0), .boostLowStrapBank0(lo0),
        .boostHighStrapBank1(hi1), .boostLowStrapBank1(lo1), .terminationSenseControl(termCtl),
        .powerDownInput(powerDownInput), .farTermSeen(farTermSeen), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .response(response), .eqIndexBank0(eqIndexBank0),
        .eqIndexBank1(eqIndexBank1), .dcGainCode(dcGainCode), .pollStrobe(pollStrobe),
        .rxDetected(rxDetected), .inputTermOn(inputTermOn));
    rsrd_far_term_model rsrd_far_term_model_i (.clk(clk), .rst(rst), .pollStrobe(pollStrobe),
        .present(present), .dropAt(dropAt), .farTermSeen(farTermSeen));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count; case inequality so unknowns never match
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // Straps are latched after release, so every strap change needs this
    task apply_reset();
        @(posedge clk) rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : apply_reset
    // One Avalon access; request held until waitrequest seen low at an edge
    task bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                  output logic [31:0] q, output logic r);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        // Waitrequest is sampled at rising edges only; the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        r = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus_xfer
    // Counts polls until detection, then expects 50 ohm
    task run_detect(input int hits, input int misses);
        int polls, n;
        polls = 0;
        n = 0;
        @(negedge clk);
        check("term before detect", inputTermOn, 1'b0);
        while (rxDetected !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
            if (pollStrobe === 1'b1) polls++;
        end
        repeat (2) @(negedge clk);
        check("polls to detect", polls, hits + misses);
        check("term after detect", inputTermOn, 1'b1);
    endtask : run_detect
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        rsrd_row_type rw;
        logic [31:0] q;
        logic e;
        apply_reset();
        foreach (rows[i]) begin
            rw = rows[i];
            @(posedge clk);
            {modeStrap, gainStrap, hi0, lo0, hi1, lo1} <= rw[13:2];
            apply_reset();
            check("eq bank0", eqIndexBank0, (rw.mode == MODE_PIN) ? {rw.h0, rw.l0} : EQ_RESET);
            check("eq bank1", eqIndexBank1, (rw.mode == MODE_PIN) ? {rw.h1, rw.l1} : EQ_RESET);
            check("dc gain", dcGainCode, rw.gainExp);
            check("term fixed", {rxDetected, inputTermOn}, 2'b01);
            bus_xfer(1'b0, REG_STATUS, 32'h0, q, e);
            check("status mode", q[1:0], rw.mode);
        end
        // Serial mode: registers steer equalizer and gain
        bus_xfer(1'b1, REG_EQ0, 32'h0000000A, q, e);
        bus_xfer(1'b1, REG_EQ1, 32'h00000005, q, e);
        bus_xfer(1'b1, REG_GAIN, 32'h00000001, q, e);
        bus_xfer(1'b0, REG_EQ1, 32'h0, q, e);
        check("eq1 readback", q, 32'h00000005);
        check("eq bank0 reg", eqIndexBank0, 4'hA);
        check("eq bank1 reg", eqIndexBank1, 4'h5);
        check("gain reg", dcGainCode, GAIN_M3);
        bus_xfer(1'b0, 8'h20, 32'h0, q, e);
        check("unmapped error", e, 1'b1);
        check("unmapped data", q, 32'h00000000);
        // Pin mode refuses register steering
        @(posedge clk);
        {modeStrap, hi0, lo0} <= {MODE_PIN, LVL_L1, LVL_L1};
        apply_reset();
        bus_xfer(1'b1, REG_EQ0, 32'h0000000A, q, e);
        @(negedge clk);
        check("pin mode eq hold", eqIndexBank0, 4'h5);
        bus_xfer(1'b0, REG_EQ0, 32'h0, q, e);
        check("pin mode write refused", q, {28'h0, EQ_RESET});
        // Hit counts for each enabled control level
        for (int lv = 1; lv < 4; lv++) begin
            @(posedge clk) termCtl <= 2'(lv);
            apply_reset();
            run_detect((lv == 1) ? HITS_L1 : (lv == 2) ? HITS_L2 : HITS_L3, 0);
        end
        // A miss on the second poll restarts the count
        @(posedge clk);
        termCtl <= LVL_L2;
        dropAt <= 8'h02;
        apply_reset();
        run_detect(HITS_L2, 2);
        bus_xfer(1'b0, REG_STATUS, 32'h0, q, e);
        check("status det term", q[ST_TERM_BIT:ST_DET_BIT], 2'b11);
        // Power-down forces reset and high impedance, release redetects
        @(posedge clk);
        dropAt <= 8'h00;
        powerDownInput <= 1'b1;
        repeat (20) @(negedge clk);
        check("power down", {rxDetected, inputTermOn}, 2'b00);
        @(posedge clk) powerDownInput <= 1'b0;
        run_detect(HITS_L2, 0);
        // Manual restart through the control register
        bus_xfer(1'b1, REG_CTRL, 32'h00000001, q, e);
        repeat (2) @(negedge clk);
        check("restart clears", rxDetected, 1'b0);
        run_detect(HITS_L2, 0);
        report_and_stop();
    end
endmodule : redriver_strap_config_rx_detect_tb_top
